// >>> bench/af_window_cfg_tb.sv
// self-checking testbench of the autofocus window and filter configuration bank
`timescale 1ns/1ns
module af_window_cfg_tb;
    //////////////////////////////////////////////////////////////////////////////
    // note of one expected apb answer: slave error bit above read data
    typedef struct {
        string name;
        logic [32:0] val;
        logic [32:0] mask;
    } note_t;
    // register offsets and readable bits, in map order
    localparam logic [7:0] OFFS [7] = '{af_cfg_pkg::OFF_PAXEL_GRID_START,
        af_cfg_pkg::OFF_FILTER_CLEAR_COL, af_cfg_pkg::OFF_STATS_OUT_BASE,
        af_cfg_pkg::OFF_COEFF_PAIR01, af_cfg_pkg::OFF_COEFF_PAIR23,
        af_cfg_pkg::OFF_COEFF_PAIR45, af_cfg_pkg::OFF_PAXEL_WIDTH};
    localparam logic [31:0] RB_MASK [7] = '{32'h0FFF0FFF, 32'h00000FFF, 32'hFFFFFFFF,
        32'h0FFF0FFF, 32'h0FFF0FFF, 32'h0FFF0FFF, 32'h007F0000};
    logic clk; // system clock
    logic ce; // clock enable
    logic rst; // asynchronous reset
    logic psel; // apb select
    logic penable; // apb enable
    logic pwrite; // apb direction
    logic [7:0] paddr; // apb address
    logic [31:0] pwdata; // apb write data
    logic pix_valid; // pixel strobe
    logic [11:0] pix_x; // pixel column
    logic [11:0] pix_y; // pixel line
    logic frame_active; // frame level
    logic [31:0] prdata; // read data
    logic pready; // apb ready
    logic pslverr; // apb error
    logic filter_clear; // clear pulse
    logic [11:0] horiz_start; // start column copy
    logic [11:0] vert_start; // start line copy
    logic [12:0] paxel_width; // decoded width
    logic [31:0] base_active; // latched base
    logic [71:0] coeffs; // coefficient bus
    logic in_window; // window flag
    note_t notes[$]; // expected apb answers
    int error_cnt = 0; // mismatches
    int samples_checked = 0; // comparisons
    integer seed = 83655; // random seed

    //////////////////////////////////////////////////////////////////////////////
    // device under test, clock enable driven by the bench
    af_window_cfg af_window_cfg_inst (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .PIX_VALID_I(pix_valid), .PIX_X_I(pix_x), .PIX_Y_I(pix_y),
        .FRAME_ACTIVE_I(frame_active), .FILTER_CLEAR_O(filter_clear),
        .PAXEL_HORIZ_START_O(horiz_start), .PAXEL_VERT_START_O(vert_start),
        .PAXEL_WIDTH_O(paxel_width), .STATS_BASE_ACTIVE_O(base_active),
        .FILTER_COEFF_O(coeffs), .IN_WINDOW_O(in_window));

    // clock of 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    //////////////////////////////////////////////////////////////////////////////
    // compare one value, count and report
    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    // counts, verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; the expected answer is noted before the request
    task automatic apb(input logic [7:0] addr, input logic wr, input logic [31:0] data,
                       input logic [32:0] exp, input logic [32:0] mask, input string name);
        int n;
        notes.push_back('{name, exp, mask});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // wait for ready under a bound
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // write expecting no slave error
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(addr, 1'b1, data, 33'h000000000, 33'h100000000, "write error flag");
    endtask : wr

    // read expecting given data and no slave error
    task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string name);
        apb(addr, 1'b0, 32'h00000000, {1'b0, exp}, {33{1'b1}}, name);
    endtask : rd

    //////////////////////////////////////////////////////////////////////////////
    // answer watcher: takes the oldest note whenever ready is seen
    always @(posedge clk) begin : watch_apb
        note_t nt;
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                error_cnt++;
                $display("unexpected apb answer: expected none, seen %h", prdata);
            end else begin
                nt = notes.pop_front();
                chk(nt.name, {pslverr, prdata} & nt.mask, nt.val & nt.mask);
            end
        end
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    //////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin : main_seq
        int j;
        int k;
        logic [31:0] v;
        logic [31:0] b1;
        logic [31:0] b2;
        logic [31:0] pr [3];
        logic [11:0] col;
        logic [11:0] h;
        logic [11:0] vs;
        logic [11:0] px;
        logic [11:0] py;
        logic [6:0] w;
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pix_valid = 1'b0;
        pix_x = 12'h000;
        pix_y = 12'h000;
        frame_active = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values of the seven configuration words and the width output
        for (k = 0; k < 7; k++) rd(OFFS[k], 32'h00000000, "reset word");
        chk("reset width", paxel_width, 13'h0002);
        $display("test reset values done");
        // all ones, then random words: only the field bits read back
        for (j = 0; j < 2; j++) begin
            for (k = 0; k < 7; k++) begin
                v = (j == 0) ? 32'hFFFFFFFF : $random(seed);
                wr(OFFS[k], v);
                rd(OFFS[k], v & RB_MASK[k], "readback");
            end
        end
        apb(8'h20, 1'b1, 32'hFFFFFFFF, 33'h100000000, 33'h100000000, "unmapped write");
        apb(8'h20, 1'b0, 32'h00000000, 33'h100000000, {33{1'b1}}, "unmapped read");
        $display("test field masks done");
        // coefficient pairs: even index low, odd index high, signed
        pr[0] = 32'h07FF0800;
        pr[1] = $random(seed);
        pr[2] = $random(seed);
        for (k = 0; k < 3; k++) wr(OFFS[3+k], pr[k]);
        for (k = 0; k < 3; k++) rd(OFFS[3+k], pr[k] & 32'h0FFF0FFF, "coeff pair");
        for (k = 0; k < 6; k++) begin
            chk("coeff field", coeffs[k*12+:12], pr[k/2][(k%2)*16+:12]);
        end
        chk("coeff sign", $signed(coeffs[11:0]) == -12'sd2048, 1'b1);
        $display("test coefficients done");
        // paxel start positions and width
        h = 12'(({$random(seed)} % 2047) * 2 + 2);
        vs = 12'($random(seed));
        wr(af_cfg_pkg::OFF_PAXEL_GRID_START, {4'h0, h, 4'h0, vs});
        // registered copies follow the write one edge later
        @(posedge clk);
        chk("horiz start", horiz_start, h);
        chk("vert start", vert_start, vs);
        for (k = 0; k < 3; k++) begin
            w = (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : 7'($random(seed));
            wr(af_cfg_pkg::OFF_PAXEL_WIDTH, {9'h000, w, 16'h0000});
            @(posedge clk);
            chk("paxel width", paxel_width, ({6'h00, w} + 13'h0001) * 2);
        end
        $display("test paxel geometry done");
        // clear column at zero, top even value and random even value
        for (k = 0; k < 3; k++) begin
            col = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFE : 12'(({$random(seed)} % 2048) * 2);
            wr(af_cfg_pkg::OFF_FILTER_CLEAR_COL, {20'h00000, col});
            for (j = 0; j < 10; j++) begin
                pix_valid <= 1'b1;
                pix_x <= col - 12'h004 + 12'(j);
                pix_y <= 12'($random(seed));
                @(posedge clk);
                chk("filter clear", filter_clear, j == 6);
                chk("in window", in_window, (j > 0) && px >= h && py >= vs);
                px = pix_x;
                py = pix_y;
            end
            pix_valid <= 1'b0;
            @(posedge clk);
        end
        $display("test filter clear done");
        // base address: readback at once, active copy from next frame only
        b1 = $random(seed);
        wr(af_cfg_pkg::OFF_STATS_OUT_BASE, b1);
        rd(af_cfg_pkg::OFF_STATS_OUT_BASE, b1, "base readback");
        chk("base before frame", base_active, 32'h00000000);
        // frame starts while the clock enable is low: nothing may move
        ce <= 1'b0;
        frame_active <= 1'b1;
        repeat (6) @(posedge clk);
        chk("base frozen", base_active, 32'h00000000);
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        chk("base first frame", base_active, b1 & 32'hFFFFFFC0);
        apb(af_cfg_pkg::OFF_STATUS, 1'b0, 32'h0, 33'h000000001, 33'h100000001, "frame flag");
        b2 = $random(seed);
        wr(af_cfg_pkg::OFF_STATS_OUT_BASE, b2);
        rd(af_cfg_pkg::OFF_STATS_OUT_BASE, b2, "base mid frame");
        chk("base kept", base_active, b1 & 32'hFFFFFFC0);
        frame_active <= 1'b0;
        repeat (6) @(posedge clk);
        frame_active <= 1'b1;
        repeat (6) @(posedge clk);
        chk("base next frame", base_active, b2 & 32'hFFFFFFC0);
        $display("test base address done");
        // second reset in mid run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("coeff after reset", coeffs === 72'h0, 1'b1);
        rst <= 1'b0;
        @(posedge clk);
        rd(af_cfg_pkg::OFF_COEFF_PAIR01, 32'h00000000, "pair after reset");
        $display("test second reset done");
        // let the watcher drain its notes
        for (j = 0; j < 20 && notes.size() > 0; j++) @(posedge clk);
        if (notes.size() > 0) error_cnt++;
        complete_run();
    end
endmodule : af_window_cfg_tb

// >>> include/af_cfg_pkg.sv
// package: register map, field layout and timing constants of the autofocus configuration bank
package af_cfg_pkg;
    // register byte offsets (no offsets printed, chosen locally)
    localparam logic [7:0] OFF_PAXEL_GRID_START = 8'h00;
    localparam logic [7:0] OFF_FILTER_CLEAR_COL = 8'h04;
    localparam logic [7:0] OFF_STATS_OUT_BASE = 8'h08;
    localparam logic [7:0] OFF_COEFF_PAIR01 = 8'h0C;
    localparam logic [7:0] OFF_COEFF_PAIR23 = 8'h10;
    localparam logic [7:0] OFF_COEFF_PAIR45 = 8'h14;
    localparam logic [7:0] OFF_PAXEL_WIDTH = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    // field positions
    localparam int HI_LSB = 16;
    localparam int LO_LSB = 0;
    localparam int FIELD_W = 12;
    localparam int PAXEL_WIDTH_FIELD_LSB = 16;
    localparam int PAXEL_WIDTH_FIELD_W = 7;
    localparam int BASE_DROP = 6;
    // masks of field bits; MASK_BASE holds the bits kept in the active base
    localparam logic [31:0] MASK_PAIR = 32'h0FFF0FFF;
    localparam logic [31:0] MASK_LOW12 = 32'h00000FFF;
    localparam logic [31:0] MASK_PAXEL_WIDTH_FIELD = 32'h007F0000;
    localparam logic [31:0] MASK_BASE = 32'hFFFFFFC0;
    // reset values
    localparam logic [31:0] RST_REG = 32'h00000000;
    localparam logic [11:0] RST_FIELD = 12'h000;
    // number of coefficients held
    localparam int NUM_COEFF = 6;
    // pipeline latency: the clear pulse rises one cycle after the matching pixel, on the edge that takes the next valid pixel
    localparam int CLEAR_DELAY = 1;
    // register file index width
    localparam int IDX_W = 3;
endpackage : af_cfg_pkg

// >>> verilog/af_reg_mem.sv
// small register memory with registered read data, used for the coefficient pairs
`timescale 1ns/1ns
module af_reg_mem #(
    parameter int DEPTH = 3,
    parameter int AW = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [31:0] wdata_i,
    // read port
    input wire logic [AW-1:0] raddr_i,
    output logic [31:0] rdata_o,
    // all words, flat, for the datapath
    output logic [DEPTH*32-1:0] words_o
);
    logic [31:0] mem_q [DEPTH]; // storage words
    // writes, reset to zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= af_cfg_pkg::RST_REG;
            end
        end else if (ce_i && we_i) begin
            mem_q[waddr_i] <= wdata_i & af_cfg_pkg::MASK_PAIR;
        end
    end
    // registered read data
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= af_cfg_pkg::RST_REG;
        end else if (ce_i) begin
            rdata_o <= (int'(raddr_i) < DEPTH) ? mem_q[raddr_i] : af_cfg_pkg::RST_REG;
        end
    end
    // flat view
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            words_o[i*32 +: 32] = mem_q[i];
        end
    end
endmodule : af_reg_mem

// >>> verilog/af_sync2.sv
// two flip-flop synchroniser for frame boundary level
`timescale 1ns/1ns
module af_sync2 (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // data
    input wire logic d_i,
    output logic q_o
);
    logic meta_q; // first stage, read only by second stage
    // two stage capture
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : af_sync2

// >>> verilog/af_window_cfg.sv
// autofocus window and filter configuration bank with APB slave
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module af_window_cfg (
    // clock, enable, reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // pixel position from the engine (same clock)
    input wire logic PIX_VALID_I,
    input wire logic [11:0] PIX_X_I,
    input wire logic [11:0] PIX_Y_I,
    // frame boundary level from the sensor side (asynchronous)
    input wire logic FRAME_ACTIVE_I,
    // configuration to the datapath
    output logic FILTER_CLEAR_O,
    output logic [11:0] PAXEL_HORIZ_START_O,
    output logic [11:0] PAXEL_VERT_START_O,
    output logic [12:0] PAXEL_WIDTH_O,
    output logic [31:0] STATS_BASE_ACTIVE_O,
    output logic [6*12-1:0] FILTER_COEFF_O,
    output logic IN_WINDOW_O
);
    //////////////////////////////////////////////////////////////////////////
    // helpers
    // pick coefficient i out of its pair word: even index low, odd index high
    function automatic logic [11:0] coeff_pick(input logic [3*32-1:0] words, input int i);
        coeff_pick = words[(i/2)*32 + ((i%2 != 0) ? af_cfg_pkg::HI_LSB
            : af_cfg_pkg::LO_LSB) +: 12];
    endfunction : coeff_pick
    // pack two 12-bit fields into the pair layout
    function automatic logic [31:0] pack_pair(input logic [11:0] hi, input logic [11:0] lo);
        pack_pair = {4'h0, hi, 4'h0, lo};
    endfunction : pack_pair

    //////////////////////////////////////////////////////////////////////////
    // bus decode
    logic setup_ph; // first cycle of a transfer
    logic wr_en; // write takes effect
    logic [31:0] rd_mux; // combinational read data
    logic addr_ok; // address maps to a register
    logic mem_sel; // address maps to coefficient memory
    logic [1:0] mem_idx; // coefficient word index
    logic [31:0] mem_rdata; // registered memory read data
    logic [3*32-1:0] coeff_words; // coefficient words, flat
    logic mem_sel_q; // read phase uses memory data
    logic [31:0] rd_hold_q; // registered other read data
    logic busy_q; // access phase in progress

    // setup cycle detected, answer one cycle later
    assign setup_ph = PSEL_I && !PENABLE_I;
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && CE_I;

    // address range check and coefficient index
    always_comb begin
        addr_ok = 1'b0;
        mem_sel = 1'b0;
        mem_idx = 2'h0;
        unique case (PADDR_I)
            af_cfg_pkg::OFF_PAXEL_GRID_START,
            af_cfg_pkg::OFF_FILTER_CLEAR_COL,
            af_cfg_pkg::OFF_STATS_OUT_BASE,
            af_cfg_pkg::OFF_PAXEL_WIDTH,
            af_cfg_pkg::OFF_STATUS: begin
                addr_ok = 1'b1;
            end
            af_cfg_pkg::OFF_COEFF_PAIR01: begin
                addr_ok = 1'b1;
                mem_sel = 1'b1;
                mem_idx = 2'h0;
            end
            af_cfg_pkg::OFF_COEFF_PAIR23: begin
                addr_ok = 1'b1;
                mem_sel = 1'b1;
                mem_idx = 2'h1;
            end
            af_cfg_pkg::OFF_COEFF_PAIR45: begin
                addr_ok = 1'b1;
                mem_sel = 1'b1;
                mem_idx = 2'h2;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [11:0] paxel_horiz_start_q; // first paxel column
    logic [11:0] paxel_vert_start_q; // first paxel line
    logic [11:0] filter_start_column_q; // filter clear column
    logic [31:0] stats_base_address_q; // latest written base
    logic [31:0] stats_base_active_q; // base latched for current frame
    logic [6:0] paxel_width_field_q; // paxel width field

    // paxel start, clear column and paxel width field registers
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            paxel_horiz_start_q <= af_cfg_pkg::RST_FIELD;
            paxel_vert_start_q <= af_cfg_pkg::RST_FIELD;
            filter_start_column_q <= af_cfg_pkg::RST_FIELD;
            paxel_width_field_q <= 7'h00;
        end else if (wr_en) begin
            if (PADDR_I == af_cfg_pkg::OFF_PAXEL_GRID_START) begin
                // start fields stored as written
                paxel_horiz_start_q <= PWDATA_I[af_cfg_pkg::HI_LSB +: af_cfg_pkg::FIELD_W];
                paxel_vert_start_q <= PWDATA_I[af_cfg_pkg::LO_LSB +: af_cfg_pkg::FIELD_W];
            end
            if (PADDR_I == af_cfg_pkg::OFF_FILTER_CLEAR_COL) begin
                // even value expected from software
                filter_start_column_q <= PWDATA_I[af_cfg_pkg::LO_LSB +: af_cfg_pkg::FIELD_W];
            end
            if (PADDR_I == af_cfg_pkg::OFF_PAXEL_WIDTH) begin
                paxel_width_field_q <= PWDATA_I[af_cfg_pkg::PAXEL_WIDTH_FIELD_LSB +: af_cfg_pkg::PAXEL_WIDTH_FIELD_W];
            end
        end
    end

    // base address shadow: writable at any time, even mid-frame
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stats_base_address_q <= af_cfg_pkg::RST_REG;
        end else if (wr_en && PADDR_I == af_cfg_pkg::OFF_STATS_OUT_BASE) begin
            stats_base_address_q <= PWDATA_I;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // frame boundary
    logic frame_s; // synchronised frame level
    logic frame_d1_q; // previous synchronised level
    logic frame_start; // rising edge of frame

    af_sync2 af_sync2_inst (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .d_i(FRAME_ACTIVE_I),
        .q_o(frame_s)
    );

    // edge detect on synchronised frame level
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            frame_d1_q <= 1'b0;
        end else if (CE_I) begin
            frame_d1_q <= frame_s;
        end
    end
    assign frame_start = frame_s && !frame_d1_q;

    // active base taken only at frame start, low bits dropped
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stats_base_active_q <= af_cfg_pkg::RST_REG;
        end else if (CE_I && frame_start) begin
            stats_base_active_q <= stats_base_address_q & af_cfg_pkg::MASK_BASE;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // coefficient memory
    af_reg_mem #(
        .DEPTH(3),
        .AW(2)
    ) af_reg_mem_inst (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .we_i(wr_en && mem_sel),
        .waddr_i(mem_idx),
        .wdata_i(PWDATA_I),
        .raddr_i(mem_idx),
        .rdata_o(mem_rdata),
        .words_o(coeff_words)
    );

    //////////////////////////////////////////////////////////////////////////
    // read data
    // non-memory read mux, unused bits zero
    always_comb begin
        rd_mux = af_cfg_pkg::RST_REG;
        unique case (PADDR_I)
            af_cfg_pkg::OFF_PAXEL_GRID_START: begin
                rd_mux = pack_pair(paxel_horiz_start_q, paxel_vert_start_q);
            end
            af_cfg_pkg::OFF_FILTER_CLEAR_COL: begin
                rd_mux = {20'h00000, filter_start_column_q};
            end
            af_cfg_pkg::OFF_STATS_OUT_BASE: begin
                rd_mux = stats_base_address_q;
            end
            af_cfg_pkg::OFF_PAXEL_WIDTH: begin
                rd_mux = {9'h000, paxel_width_field_q, 16'h0000};
            end
            af_cfg_pkg::OFF_STATUS: begin
                rd_mux = {30'h0, IN_WINDOW_O, frame_s};
            end
            default: begin
                rd_mux = af_cfg_pkg::RST_REG;
            end
        endcase
    end

    // no wait cycle: ready in the first access cycle
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_q <= 1'b0;
            mem_sel_q <= 1'b0;
            rd_hold_q <= af_cfg_pkg::RST_REG;
            PSLVERR_O <= 1'b0;
        end else if (CE_I) begin
            busy_q <= setup_ph;
            if (setup_ph) begin
                mem_sel_q <= mem_sel;
                rd_hold_q <= rd_mux;
                PSLVERR_O <= !addr_ok;
            end else begin
                PSLVERR_O <= 1'b0;
            end
        end
    end
    // clock enable low stalls the bus as well: ready cannot rise while frozen
    assign PREADY_O = busy_q;

    // registered read data presented in access phase
    always_comb begin
        PRDATA_O = mem_sel_q ? mem_rdata : rd_hold_q;
    end

    //////////////////////////////////////////////////////////////////////////
    // filter clear strobe: column match, clear on the next pixel
    logic match_q; // match seen, waiting for next pixel
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            match_q <= 1'b0;
            FILTER_CLEAR_O <= 1'b0;
        end else if (CE_I) begin
            FILTER_CLEAR_O <= 1'b0;
            if (PIX_VALID_I) begin
                FILTER_CLEAR_O <= match_q;
                match_q <= (PIX_X_I == filter_start_column_q);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // datapath configuration outputs
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PAXEL_HORIZ_START_O <= af_cfg_pkg::RST_FIELD;
            PAXEL_VERT_START_O <= af_cfg_pkg::RST_FIELD;
            PAXEL_WIDTH_O <= 13'h0002;
            IN_WINDOW_O <= 1'b0;
        end else if (CE_I) begin
            PAXEL_HORIZ_START_O <= paxel_horiz_start_q;
            PAXEL_VERT_START_O <= paxel_vert_start_q;
            // (field + 1) * 2
            PAXEL_WIDTH_O <= {5'h00, paxel_width_field_q, 1'b0} + 13'h0002;
            IN_WINDOW_O <= PIX_VALID_I && (PIX_X_I >= paxel_horiz_start_q)
                && (PIX_Y_I >= paxel_vert_start_q);
        end
    end
    assign STATS_BASE_ACTIVE_O = stats_base_active_q;

    // coefficient fields as signed values, even low, odd high
    always_comb begin
        for (int i = 0; i < af_cfg_pkg::NUM_COEFF; i++) begin
            // fields pass unchanged: the datapath reads them as signed, six fraction bits
            FILTER_COEFF_O[i*12 +: 12] = coeff_pick(coeff_words, i);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // assertions
    base_latch_frame_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        CE_I && !frame_start |=> $stable(stats_base_active_q))
        else $error("active base changed outside frame start");
    base_aligned_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        stats_base_active_q[5:0] == 6'h00)
        else $error("active base not 64-byte aligned");
    base_readback_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_en && PADDR_I == af_cfg_pkg::OFF_STATS_OUT_BASE
        |=> stats_base_address_q == $past(PWDATA_I))
        else $error("base shadow lost written value");
    clear_next_pixel_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        CE_I && PIX_VALID_I && PIX_X_I == filter_start_column_q ##1 CE_I && PIX_VALID_I
        |=> FILTER_CLEAR_O)
        else $error("filter clear missed after column match");
    reserved_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        PREADY_O && mem_sel_q |-> (PRDATA_O & ~af_cfg_pkg::MASK_PAIR) == 32'h00000000)
        else $error("reserved coefficient bits read nonzero");
    width_calc_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        CE_I ##1 CE_I |-> PAXEL_WIDTH_O == 13'((32'(paxel_width_field_q) + 32'd1) * 32'd2)
        || $changed(paxel_width_field_q))
        else $error("paxel width mismatch");
    start_fields_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_en && PADDR_I == af_cfg_pkg::OFF_PAXEL_GRID_START
        |=> paxel_horiz_start_q == $past(PWDATA_I[27:16])
        && paxel_vert_start_q == $past(PWDATA_I[11:0]))
        else $error("paxel start fields not stored");
    coeff_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        FILTER_COEFF_O[23:12] == coeff_words[27:16] && FILTER_COEFF_O[11:0] == coeff_words[11:0])
        else $error("coefficient pair order wrong");
    ready_one_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        CE_I && setup_ph |=> PREADY_O)
        else $error("ready not given after setup");
    // ready is a single pulse while the clock enable stays high, so a held request cannot be answered twice
    ready_single_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        CE_I && PREADY_O |=> !PREADY_O)
        else $error("ready held longer than one cycle");
    slverr_unmapped_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        CE_I && setup_ph && !addr_ok |=> PREADY_O && PSLVERR_O)
        else $error("unmapped address not refused");
    // a low clock enable freezes bus, frame and pixel state alike
    ce_freeze_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !CE_I |=> $stable(stats_base_active_q) && $stable(FILTER_CLEAR_O) && $stable(PREADY_O))
        else $error("state moved while clock enable low");
    frame_start_c: cover property (@(posedge SYS_CLK_I) disable iff (RST_I) frame_start);
    clear_pulse_c: cover property (@(posedge SYS_CLK_I) disable iff (RST_I) FILTER_CLEAR_O);
    base_write_c: cover property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_en && PADDR_I == af_cfg_pkg::OFF_STATS_OUT_BASE && frame_s);
    slverr_c: cover property (@(posedge SYS_CLK_I) disable iff (RST_I) PREADY_O && PSLVERR_O);
endmodule : af_window_cfg
